// [inc/sps_consts.svh]
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH
// Notes on behaviour
// - status byte out during first bytes
// - status bits: oscillator, cipher, transmit, lock
// - underflow bit sticky until transmit flush
// - signal strength valid after 128 us
// - no-op strobe only returns status
// - strobes 0x01 to 0x0E start sequences
// - oscillator off: only oscillator-on accepted
// - other strobes dropped until oscillator stable
// - strobe fires on last falling edge
// - RAM address taken once, auto-increments
// - RAM address: flag, in-bank, bank, read-only
// - banks: transmit, receive, security 112 bytes
// - RAM write returns old contents meanwhile
// - RAM writes never touch queue counters
// - 0x3E transmit write, 0x3F receive both
// - fresh status per transmit queue byte
// - queue or RAM access ends at release
// - flush strobes empty their queues
// - accesses chain within one select period
// - register access may end early cleanly
// - most significant bit first
// - sample serial input on rising clock
// - register cycle is 24 bits
// - serial output released while deselected
`define SPS_OFS_TXQ 6'h3E
`define SPS_OFS_RXQ 6'h3F
`define SPS_STB_LAST 6'h0E
`define SPS_STB_NOP 4'h0
`define SPS_STB_OSC 4'h1
`define SPS_STB_FLRX 4'h8
`define SPS_STB_FLTX 4'h9
`define SPS_ST_OSC 6
`define SPS_ST_UFL 5
`define SPS_ST_ENC 4
`define SPS_ST_TXA 3
`define SPS_ST_LOCK 2
`define SPS_ST_RSSI 1
`define SPS_QUEUE_BYTES 8'h80
`define SPS_SEC_BYTES 7'h70
`define SPS_RAM_BYTES 'h170
`define SPS_CLK_NS 5
`define SPS_RSSI_NS 128000
`define SPS_RSSI_CYC ((`SPS_RSSI_NS + `SPS_CLK_NS - 1) / `SPS_CLK_NS)
`endif

// [inc/sps_pkg.sv]
package sps_pkg;
   typedef enum logic [2:0] {
      ST_CMD, ST_REGHI, ST_REGLO, ST_ADR2, ST_RAMD, ST_QTX, ST_QRX
   } sps_state_e;
   typedef logic [7:0] sps_byte_t;
endpackage

// [inc/sps_stream_if.sv]
`timescale 1ns/10ps
// =====================================================
// byte stream with valid and ready
interface sps_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// [hdl/sps_fifo.sv]
`timescale 1ns/10ps
// =====================================================
// small first-in first-out buffer
module sps_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8
) (
   input wire logic core_clk, // system clock
   input wire logic rst, // synchronous reset
   sps_stream_if.snk up, // filling side
   sps_stream_if.src dn // draining side
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_q [0:DEPTH-1];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic full;
   logic empty;

   // pointer arithmetic relies on a power of two depth
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("sps_fifo depth must be a power of two");
   end

   // extra pointer bit tells full from empty
   assign empty = (wr_q == rd_q);
   assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign up.ready = ~full;
   assign dn.valid = ~empty;
   assign dn.data = mem_q[rd_q[AW-1:0]];

   // write side
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_q <= '0;
      end else if (up.valid && !full) begin
         mem_q[wr_q[AW-1:0]] <= up.data;
         wr_q <= wr_q + 1'b1;
      end
   end

   // read side
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd_q <= '0;
      end else if (dn.ready && !empty) begin
         rd_q <= rd_q + 1'b1;
      end
   end
endmodule // sps_fifo

// [hdl/sps_top.sv]
`timescale 1ns/10ps
`include "sps_consts.svh"
// =====================================================
// serial slave front end with banked RAM and queues
module sps_top #(
   parameter int unsigned RSSI_CYC = `SPS_RSSI_CYC,
   parameter int QDEPTH = 8
) (
   input wire logic core_clk, // 200 MHz system clock
   input wire logic rst, // synchronous, active high
   input wire logic chip_select_n, // serial select pin
   input wire logic sclk, // serial clock pin
   input wire logic si, // serial data in pin
   output logic so, // serial data out
   output logic so_oe, // high while so is driven
   input wire logic osc_running, // oscillator stable
   input wire logic cipher_busy, // cipher engine busy
   input wire logic tx_active, // radio transmitting
   input wire logic pll_lock, // synthesizer locked
   input wire logic rx_enabled, // reception enabled
   output logic [14:0] strobe_pulse, // one per strobe
   output logic [5:0] reg_addr, // register address
   output logic [15:0] reg_wdata, // register write data
   output logic reg_write, // register write pulse
   input wire logic [15:0] reg_rdata, // register read data
   input wire logic tx_take, // modem wants a byte
   output logic [7:0] tx_byte, // byte to modem
   output logic tx_byte_valid, // tx_byte fresh pulse
   input wire logic rx_in_valid, // received byte valid
   input wire logic [7:0] rx_in_data, // received byte
   output logic rx_in_ready // buffer accepts byte
);
   // a one-cycle validity delay would let the flag rise with no reception
   if (QDEPTH < 2 || RSSI_CYC < 2) begin : g_chk
      $error("sps_top queue depth or validity delay too small");
   end

   // =====================================================
   // pin synchronisers and edge finding
   logic [2:0] p1_q;
   logic [2:0] p2_q;
   logic sclk_p_q;
   logic cs_s, sclk_s, si_s, rise, fall;
   assign cs_s = p2_q[2];
   assign sclk_s = p2_q[1];
   assign si_s = p2_q[0];

   // two stages before any logic looks at a pin
   always_ff @(posedge core_clk) begin
      if (rst) begin
         p1_q <= 3'h4;
         p2_q <= 3'h4;
         sclk_p_q <= 1'b0;
      end else begin
         p1_q <= {chip_select_n, sclk, si};
         p2_q <= p1_q;
         sclk_p_q <= sclk_s;
      end
   end
   assign rise = sclk_s & ~sclk_p_q & ~cs_s;
   assign fall = ~sclk_s & sclk_p_q & ~cs_s;

   // =====================================================
   // status byte
   logic ufl_q, rssi_q, osc_ok;
   logic [31:0] rssi_cnt_q;
   sps_pkg::sps_byte_t status_w;
   assign osc_ok = osc_running;
   always_comb begin
      status_w = 8'h00; // reserved bits read zero
      status_w[`SPS_ST_OSC] = osc_ok;
      status_w[`SPS_ST_UFL] = ufl_q;
      status_w[`SPS_ST_ENC] = cipher_busy;
      status_w[`SPS_ST_TXA] = tx_active;
      status_w[`SPS_ST_LOCK] = pll_lock;
      status_w[`SPS_ST_RSSI] = rssi_q;
   end

   // validity counts reception time, saturates at the mark
   always_ff @(posedge core_clk) begin
      if (rst || !rx_enabled) begin
         rssi_cnt_q <= 32'h0;
         rssi_q <= 1'b0;
      end else if (rssi_cnt_q >= RSSI_CYC - 1) begin
         rssi_q <= 1'b1;
      end else begin
         rssi_cnt_q <= rssi_cnt_q + 32'h1;
      end
   end

   // =====================================================
   // RAM and its queues
   logic [7:0] mem_q [0:`SPS_RAM_BYTES-1];
   logic [6:0] tx_head_q, tx_tail_q, rx_head_q, rx_tail_q;
   logic [7:0] tx_cnt_q, rx_cnt_q;

   // a location is real unless bank 3 or past the security area
   function automatic logic ram_ok(input logic [8:0] a);
      ram_ok = (a[8:7] != 2'h3) &&
         !(a[8:7] == 2'h2 && a[6:0] >= `SPS_SEC_BYTES);
   endfunction

   function automatic sps_pkg::sps_byte_t ram_rd(input logic [8:0] a);
      ram_rd = ram_ok(a) ? mem_q[a] : 8'h00;
   endfunction

   // =====================================================
   // serial engine
   sps_pkg::sps_state_e st_q;
   logic [2:0] bit_q;
   logic [7:0] in_sr_q, out_sr_q, nxt_q, rd_lo_q, byte_in;
   logic [8:0] ram_ptr_q;
   logic ram_ro_q, rx_wr_q, reg_rd_q;
   logic stb_pend_q, wr_pend_q, done, stb_fire, is_stb;
   logic [3:0] stb_code_q;
   logic [15:0] wd_q;
   logic spi_we, rx_pop, tx_push, rx_push_spi, drain, flush_tx, flush_rx;
   logic [8:0] spi_wa;

   assign byte_in = {in_sr_q[6:0], si_s};
   assign done = rise && (bit_q == 3'h7);
   assign is_stb = !byte_in[7] && byte_in[5:0] <= `SPS_STB_LAST;

   // input shift register and bit count; release aborts cleanly
   always_ff @(posedge core_clk) begin
      if (rst || cs_s) begin
         bit_q <= 3'h0;
         in_sr_q <= 8'h00;
      end else if (rise) begin
         bit_q <= bit_q + 3'h1;
         in_sr_q <= byte_in;
      end
   end

   // access sequencing, decided as each byte completes
   always_ff @(posedge core_clk) begin
      if (rst || cs_s) begin
         st_q <= sps_pkg::ST_CMD;
         nxt_q <= 8'h00;
         ram_ptr_q <= 9'h000;
         ram_ro_q <= 1'b0;
         rx_wr_q <= 1'b0;
         reg_rd_q <= 1'b0;
         reg_addr <= 6'h00;
         rd_lo_q <= 8'h00;
         wd_q <= 16'h0000;
      end else if (done) begin
         case (st_q)
            sps_pkg::ST_CMD: begin
               if (byte_in[7]) begin
                  ram_ptr_q <= {2'h0, byte_in[6:0]};
                  nxt_q <= 8'h00;
                  st_q <= sps_pkg::ST_ADR2;
               end else if (is_stb) begin
                  nxt_q <= status_w;
               end else if (byte_in[5:0] == `SPS_OFS_TXQ) begin
                  nxt_q <= status_w;
                  st_q <= sps_pkg::ST_QTX;
               end else if (byte_in[5:0] == `SPS_OFS_RXQ) begin
                  rx_wr_q <= !byte_in[6];
                  nxt_q <= (byte_in[6] && rx_cnt_q != 8'h00) ?
                     ram_rd({2'h1, rx_head_q}) : 8'h00;
                  st_q <= sps_pkg::ST_QRX;
               end else begin
                  reg_addr <= byte_in[5:0];
                  reg_rd_q <= byte_in[6];
                  nxt_q <= byte_in[6] ? reg_rdata[15:8] : 8'h00;
                  rd_lo_q <= reg_rdata[7:0];
                  st_q <= sps_pkg::ST_REGHI;
               end
            end
            sps_pkg::ST_REGHI: begin
               wd_q[15:8] <= byte_in;
               nxt_q <= reg_rd_q ? rd_lo_q : 8'h00;
               st_q <= sps_pkg::ST_REGLO;
            end
            sps_pkg::ST_REGLO: begin
               wd_q[7:0] <= byte_in;
               nxt_q <= status_w;
               st_q <= sps_pkg::ST_CMD;
            end
            sps_pkg::ST_ADR2: begin
               ram_ptr_q <= {byte_in[7:6], ram_ptr_q[6:0]};
               ram_ro_q <= byte_in[5];
               nxt_q <= ram_rd({byte_in[7:6], ram_ptr_q[6:0]});
               st_q <= sps_pkg::ST_RAMD;
            end
            sps_pkg::ST_RAMD: begin
               ram_ptr_q <= ram_ptr_q + 9'h001;
               nxt_q <= ram_rd(ram_ptr_q + 9'h001);
            end
            sps_pkg::ST_QTX: begin
               nxt_q <= status_w;
            end
            sps_pkg::ST_QRX: begin
               // head already moved past the byte now going out
               nxt_q <= (!rx_wr_q && rx_cnt_q != 8'h00) ?
                  ram_rd({2'h1, rx_head_q}) : 8'h00;
            end
            default: begin
               st_q <= sps_pkg::ST_CMD;
            end
         endcase
      end
   end

   // =====================================================
   // strobes and register writes wait for the falling edge
   always_ff @(posedge core_clk) begin
      if (rst || cs_s) begin
         stb_pend_q <= 1'b0;
         stb_code_q <= 4'h0;
         wr_pend_q <= 1'b0;
      end else if (done && st_q == sps_pkg::ST_CMD && is_stb) begin
         stb_pend_q <= 1'b1;
         stb_code_q <= byte_in[3:0];
      end else if (done && st_q == sps_pkg::ST_REGLO) begin
         wr_pend_q <= !reg_rd_q;
      end else if (fall) begin
         stb_pend_q <= 1'b0;
         wr_pend_q <= 1'b0;
      end
   end

   // only the oscillator strobe gets through until it is stable
   assign stb_fire = fall && stb_pend_q &&
      (osc_ok || stb_code_q == `SPS_STB_OSC);
   assign flush_tx = stb_fire && stb_code_q == `SPS_STB_FLTX;
   assign flush_rx = stb_fire && stb_code_q == `SPS_STB_FLRX;

   // no-op gives no pulse at all, only the status byte
   always_ff @(posedge core_clk) begin
      if (rst) begin
         strobe_pulse <= 15'h0000;
         reg_write <= 1'b0;
         reg_wdata <= 16'h0000;
      end else begin
         strobe_pulse <= 15'h0000;
         reg_write <= fall && wr_pend_q;
         if (fall && wr_pend_q) begin
            reg_wdata <= wd_q;
         end
         if (stb_fire && stb_code_q != `SPS_STB_NOP) begin
            strobe_pulse[stb_code_q] <= 1'b1;
         end
      end
   end

   // =====================================================
   // serial output shifts after each falling edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         so <= 1'b0;
         so_oe <= 1'b0;
         out_sr_q <= 8'h00;
      end else begin
         so_oe <= ~cs_s;
         if (cs_s) begin
            so <= status_w[7];
            out_sr_q <= {status_w[6:0], 1'b0};
         end else if (fall && bit_q == 3'h0) begin
            so <= nxt_q[7];
            out_sr_q <= {nxt_q[6:0], 1'b0};
         end else if (fall) begin
            so <= out_sr_q[7];
            out_sr_q <= {out_sr_q[6:0], 1'b0};
         end
      end
   end

   // =====================================================
   // RAM write port and queue bookkeeping
   assign tx_push = done && st_q == sps_pkg::ST_QTX &&
      tx_cnt_q < `SPS_QUEUE_BYTES;
   assign rx_push_spi = done && st_q == sps_pkg::ST_QRX && rx_wr_q &&
      rx_cnt_q < `SPS_QUEUE_BYTES;
   assign rx_pop = rx_cnt_q != 8'h00 &&
      ((done && st_q == sps_pkg::ST_QRX && !rx_wr_q) ||
       (done && st_q == sps_pkg::ST_CMD && !byte_in[7] && byte_in[6] &&
        byte_in[5:0] == `SPS_OFS_RXQ));
   // plain RAM writes bypass the counters
   assign spi_we = tx_push || rx_push_spi || (done &&
      st_q == sps_pkg::ST_RAMD && !ram_ro_q && ram_ok(ram_ptr_q));
   assign spi_wa = tx_push ? {2'h0, tx_tail_q} :
      rx_push_spi ? {2'h1, rx_tail_q} : ram_ptr_q;

   // buffered received bytes drain when the port is free
   sps_stream_if #(.W(8)) up_s ();
   sps_stream_if #(.W(8)) dn_s ();
   assign up_s.valid = rx_in_valid;
   assign up_s.data = rx_in_data;
   assign rx_in_ready = up_s.ready;
   assign drain = dn_s.valid && !spi_we && !rx_pop &&
      rx_cnt_q < `SPS_QUEUE_BYTES && !flush_rx;
   assign dn_s.ready = drain;

   sps_fifo #(.W(8), .DEPTH(QDEPTH)) u_rx_buf (
      .core_clk(core_clk),
      .rst(rst),
      .up(up_s),
      .dn(dn_s)
   );

   // single write port, serial side has priority
   always_ff @(posedge core_clk) begin
      if (spi_we) begin
         mem_q[spi_wa] <= byte_in;
      end else if (drain) begin
         mem_q[{2'h1, rx_tail_q}] <= dn_s.data;
      end
   end

   // transmit queue pointers; flush wins over traffic
   always_ff @(posedge core_clk) begin
      if (rst || flush_tx) begin
         tx_head_q <= 7'h00;
         tx_tail_q <= 7'h00;
         tx_cnt_q <= 8'h00;
         tx_byte_valid <= 1'b0;
      end else begin
         tx_byte_valid <= tx_take && tx_cnt_q != 8'h00;
         if (tx_push) begin
            tx_tail_q <= tx_tail_q + 7'h01;
         end
         if (tx_take && tx_cnt_q != 8'h00) begin
            tx_head_q <= tx_head_q + 7'h01;
         end
         tx_cnt_q <= tx_cnt_q + {7'h00, tx_push} -
            {7'h00, tx_take && tx_cnt_q != 8'h00};
      end
   end

   // byte handed to the modem
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tx_byte <= 8'h00;
      end else if (tx_take && tx_cnt_q != 8'h00) begin
         tx_byte <= ram_rd({2'h0, tx_head_q});
      end
   end

   // underflow is sticky; a new event beats the flush
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ufl_q <= 1'b0;
      end else if (tx_take && tx_cnt_q == 8'h00 && tx_active) begin
         ufl_q <= 1'b1;
      end else if (flush_tx) begin
         ufl_q <= 1'b0;
      end
   end

   // receive queue pointers
   always_ff @(posedge core_clk) begin
      if (rst || flush_rx) begin
         rx_head_q <= 7'h00;
         rx_tail_q <= 7'h00;
         rx_cnt_q <= 8'h00;
      end else begin
         if (rx_push_spi || drain) begin
            rx_tail_q <= rx_tail_q + 7'h01;
         end
         if (rx_pop) begin
            rx_head_q <= rx_head_q + 7'h01;
         end
         rx_cnt_q <= rx_cnt_q + {7'h00, rx_push_spi || drain} -
            {7'h00, rx_pop};
      end
   end

   // =====================================================
   // checks
   property p_oe_off;
      @(posedge core_clk) disable iff (rst)
         cs_s |=> !so_oe;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("so driven while deselected");

   property p_osc_gate;
      @(posedge core_clk) disable iff (rst)
         (!osc_ok && stb_pend_q && fall && stb_code_q != `SPS_STB_OSC)
         |=> strobe_pulse == 15'h0000;
   endproperty
   a_osc_gate: assert property (p_osc_gate)
      else $error("strobe passed while oscillator off");

   property p_stb_fall;
      @(posedge core_clk) disable iff (rst)
         (strobe_pulse != 15'h0000) |-> $past(fall) && $past(!cs_s);
   endproperty
   a_stb_fall: assert property (p_stb_fall)
      else $error("strobe not on falling edge");

   property p_ufl_hold;
      @(posedge core_clk) disable iff (rst)
         (ufl_q && !flush_tx) |=> ufl_q;
   endproperty
   a_ufl_hold: assert property (p_ufl_hold)
      else $error("underflow cleared without flush");

   property p_ufl_clr;
      @(posedge core_clk) disable iff (rst)
         (flush_tx && !(tx_take && tx_active)) |=> !ufl_q && tx_cnt_q == 8'h00;
   endproperty
   a_ufl_clr: assert property (p_ufl_clr)
      else $error("flush left transmit state");

   property p_rssi;
      @(posedge core_clk) disable iff (rst)
         !rx_enabled |=> !status_w[`SPS_ST_RSSI] [*2];
   endproperty
   a_rssi: assert property (p_rssi)
      else $error("signal strength valid without reception");

   property p_stat_next;
      @(posedge core_clk) disable iff (rst)
         (done && st_q == sps_pkg::ST_CMD && !byte_in[7] &&
          (is_stb || byte_in[5:0] == `SPS_OFS_TXQ))
         |=> nxt_q == $past(status_w);
   endproperty
   a_stat_next: assert property (p_stat_next)
      else $error("status not queued after strobe or queue byte");

   property p_rx_bound;
      @(posedge core_clk) disable iff (rst)
         rx_cnt_q <= `SPS_QUEUE_BYTES && tx_cnt_q <= `SPS_QUEUE_BYTES;
   endproperty
   a_rx_bound: assert property (p_rx_bound)
      else $error("queue count past 128");

   property p_reg_wr;
      @(posedge core_clk) disable iff (rst)
         reg_write |-> $past(fall) ##1 !reg_write;
   endproperty
   a_reg_wr: assert property (p_reg_wr)
      else $error("register write not a falling-edge pulse");
endmodule // sps_top

// [verif/sps_spi_master.sv]
`timescale 1ns/10ps
// =====================================================
// host model: drives select, clock and data pins
module sps_spi_master (
   input wire logic core_clk, // pacing clock
   input wire logic so_pin, // resolved serial out
   output logic chip_select_n, // select, active low
   output logic sclk, // serial clock, 125 ns period
   output logic si // serial data to the device
);
   // idle: select high, clock parked low, data pulled up
   initial begin
      chip_select_n = 1'b1;
      sclk = 1'b0;
      si = 1'b1;
   end
   // select with setup margin before the first rise
   task automatic sel();
      @(negedge core_clk);
      chip_select_n = 1'b0;
      repeat (13) @(negedge core_clk);
   endtask
   // release only after the last fall; queue and RAM end here
   task automatic desel();
      repeat (13) @(negedge core_clk);
      chip_select_n = 1'b1;
      si = 1'b1;
      repeat (20) @(negedge core_clk);
   endtask
   // one byte each way; the clock only runs inside frames
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         si = tx[i];
         repeat (13) @(negedge core_clk);
         sclk = 1'b1;
         rx[i] = so_pin; // sampled at the rise
         repeat (12) @(negedge core_clk);
         sclk = 1'b0;
      end
   endtask
endmodule // sps_spi_master

// [verif/tb.sv]
`timescale 1ns/10ps
// =====================================================
// bench: host model drives the pins, tasks check replies
module tb;
   localparam int RCYC = 400; // short validity delay
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic chip_select_n, sclk, si, so, so_oe, so_pin;
   logic osc_running = 1'b0;
   logic cipher_busy = 1'b1;
   logic tx_active = 1'b0;
   logic pll_lock = 1'b1;
   logic rx_enabled = 1'b0;
   logic [14:0] strobe_pulse;
   logic [5:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_write;
   logic [15:0] reg_rdata = 16'h1234;
   logic tx_take = 1'b0;
   logic [7:0] tx_byte;
   logic tx_byte_valid;
   logic rx_in_valid = 1'b0;
   logic [7:0] rx_in_data = 8'h00;
   logic rx_in_ready;
   logic [7:0] r;
   logic [14:0] seen = '0;
   logic [21:0] wr = '0;
   logic ufl = 1'b0;
   logic rssi = 1'b0;
   int nwr = 0;
   int fail_count = 0;
   int total_checks = 0;
   logic [7:0] txq[$];
   logic [7:0] td[3] = '{8'hA1, 8'h5E, 8'h07};

   always #2.5 core_clk = ~core_clk;
   // released output floats up to the host's pull-up
   assign so_pin = so_oe ? so : 1'b1;

   sps_top #(.RSSI_CYC(RCYC), .QDEPTH(8)) i_sps_top (
      .core_clk(core_clk), .rst(rst), .chip_select_n(chip_select_n),
      .sclk(sclk), .si(si), .so(so), .so_oe(so_oe),
      .osc_running(osc_running), .cipher_busy(cipher_busy),
      .tx_active(tx_active), .pll_lock(pll_lock),
      .rx_enabled(rx_enabled), .strobe_pulse(strobe_pulse),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_rdata(reg_rdata), .tx_take(tx_take), .tx_byte(tx_byte),
      .tx_byte_valid(tx_byte_valid), .rx_in_valid(rx_in_valid),
      .rx_in_data(rx_in_data), .rx_in_ready(rx_in_ready));
   sps_spi_master i_sps_spi_master (
      .core_clk(core_clk), .so_pin(so_pin),
      .chip_select_n(chip_select_n), .sclk(sclk), .si(si));

   // one-cycle pulses are caught here so no check can miss them
   always @(posedge core_clk) begin
      seen <= seen | strobe_pulse;
      if (reg_write === 1'b1) begin
         wr <= {reg_addr, reg_wdata};
         nwr <= nwr + 1;
      end
      if (tx_byte_valid === 1'b1) txq.push_back(tx_byte);
   end

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [21:0] e,
      input logic [21:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   function automatic logic [7:0] st();
      return {1'b0, osc_running, ufl, cipher_busy, tx_active, pll_lock,
         rssi, 1'b0};
   endfunction
   task automatic x(input logic [7:0] b);
      i_sps_spi_master.xfer(b, r);
   endtask
   // byte out, status back; reserved bits are masked
   task automatic xs(input logic [7:0] b);
      x(b);
      chk("status", 22'(st() & 8'h7E), 22'(r & 8'h7E));
   endtask
   task automatic done(input string name);
      $display("test %s finished", name);
   endtask
   // bounded wait for space in the receive buffer
   task automatic push(input logic [7:0] b);
      int n;
      n = 0;
      @(negedge core_clk);
      rx_in_valid = 1'b1;
      rx_in_data = b;
      while (rx_in_ready !== 1'b1 && n < 50) begin
         @(negedge core_clk);
         n++;
      end
      @(negedge core_clk);
      rx_in_valid = 1'b0;
      if (n == 50) begin
         fail_count++;
         results();
      end
   endtask
   // one-cycle request for the next transmit byte
   task automatic take();
      @(negedge core_clk);
      tx_take = 1'b1;
      @(negedge core_clk);
      tx_take = 1'b0;
      repeat (3) @(negedge core_clk);
   endtask

   initial begin
      repeat (12) @(negedge core_clk);
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      // oscillator off: only the oscillator-on strobe acts
      i_sps_spi_master.sel();
      xs(8'h09);
      xs(8'h02);
      i_sps_spi_master.desel();
      chk("strobes", 22'h0, 22'(seen));
      chk("so_oe", 22'h0, 22'(so_oe));
      i_sps_spi_master.sel();
      xs(8'h01);
      i_sps_spi_master.desel();
      chk("strobes", 22'h0002, 22'(seen));
      osc_running = 1'b1;
      done("oscillator");
      // no-op, then every strobe chained with a register write
      seen = '0;
      i_sps_spi_master.sel();
      xs(8'h00);
      for (int k = 1; k < 15; k++) xs(8'(k));
      x(8'h15);
      x(8'hA5);
      x(8'hC3);
      i_sps_spi_master.desel();
      chk("strobes", 22'h7FFE, 22'(seen));
      chk("reg write", {6'h15, 16'hA5C3}, wr);
      // register read, then a write cut short by release
      i_sps_spi_master.sel();
      xs(8'h55);
      x(8'h00);
      chk("read hi", 22'h12, 22'(r));
      x(8'h00);
      chk("read lo", 22'h34, 22'(r));
      x(8'h17);
      x(8'hFF);
      i_sps_spi_master.desel();
      chk("writes", 22'h1, 22'(nwr));
      done("registers");
      // transmit queue: status per byte, then modem drains it
      i_sps_spi_master.sel();
      xs(8'h3E);
      for (int k = 0; k < 3; k++) xs(td[k]);
      i_sps_spi_master.desel();
      repeat (3) take();
      for (int k = 0; k < 3; k++) chk("tx byte", 22'(td[k]), 22'(txq[k]));
      tx_active = 1'b1;
      take();
      ufl = 1'b1;
      i_sps_spi_master.sel();
      xs(8'h00);
      xs(8'h00);
      x(8'h09);
      ufl = 1'b0;
      x(8'h00);
      xs(8'h00);
      i_sps_spi_master.desel();
      tx_active = 1'b0;
      done("transmit queue");
      // security bank: write, overwrite, read back with increment
      i_sps_spi_master.sel();
      xs(8'h90);
      x(8'h80);
      x(8'hDE);
      x(8'hAD);
      i_sps_spi_master.desel();
      i_sps_spi_master.sel();
      x(8'h90);
      x(8'h80);
      x(8'h11);
      chk("ram old", 22'hDE, 22'(r));
      i_sps_spi_master.desel();
      i_sps_spi_master.sel();
      x(8'h90);
      x(8'hA0);
      x(8'h00);
      chk("ram rd0", 22'h11, 22'(r));
      x(8'h00);
      chk("ram rd1", 22'hAD, 22'(r));
      i_sps_spi_master.desel();
      done("ram");
      // receive queue read, then flush empties it
      push(8'h3C);
      push(8'hC3);
      repeat (20) @(negedge core_clk);
      i_sps_spi_master.sel();
      x(8'h7F);
      x(8'h00);
      chk("rx 0", 22'h3C, 22'(r));
      x(8'h00);
      chk("rx 1", 22'hC3, 22'(r));
      i_sps_spi_master.desel();
      push(8'h77);
      repeat (20) @(negedge core_clk);
      i_sps_spi_master.sel();
      x(8'h08);
      i_sps_spi_master.desel();
      i_sps_spi_master.sel();
      x(8'h7F);
      x(8'h00);
      chk("rx empty", 22'h0, 22'(r));
      i_sps_spi_master.desel();
      // host writes the receive queue, then reads it back
      i_sps_spi_master.sel();
      x(8'h3F);
      x(8'h5A);
      i_sps_spi_master.desel();
      i_sps_spi_master.sel();
      x(8'h7F);
      x(8'h00);
      chk("rx written", 22'h5A, 22'(r));
      i_sps_spi_master.desel();
      done("receive queue");
      // signal strength valid only after the enable delay
      rx_enabled = 1'b1;
      i_sps_spi_master.sel();
      xs(8'h00);
      i_sps_spi_master.desel();
      repeat (RCYC) @(negedge core_clk);
      rssi = 1'b1;
      i_sps_spi_master.sel();
      xs(8'h00);
      i_sps_spi_master.desel();
      done("signal strength");
      results();
   end
endmodule // tb
